// >>> design/slc_top.sv
`timescale 1ns/10ps
`default_nettype none
module slc_top
  import slc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // supply threshold crossed, level
  input  wire logic        supply_ok,
  input  wire logic        crystal_input,
  // shared strap pins
  input  wire logic [3:0]  freq_select_strap_i,
  output slc_pad_t  [3:0]  freq_select_strap_pad,
  input  wire logic        processor_mode_strap_i,
  output slc_pad_t         processor_mode_pad,
  input  wire logic        current_mult_strap_i,
  output slc_pad_t         current_mult_pad,
  input  wire logic        power_good_n_in,
  output slc_pad_t         power_good_pad,
  // cpu clocks
  output slc_pad_t         cpu_true_pad,
  output slc_pad_t         cpu_comp_pad,
  output logic [1:0]       chipset_cpu_clock_pair,
  // graphics and pci clocks
  output logic [1:0]       graphics_port_clocks,
  output logic [4:0]       pci_clocks,
  // buffer configuration
  output logic             cpu_push_pull,
  output logic             cpu_current_6x,
  output logic             ref_strength_2x,
  output logic             outputs_enabled,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata
);

  // ==========================================================================
  // state
  typedef struct packed {
    slc_phase_t           st;
    logic                 mode;
    logic                 mult;
    logic [3:0]           fs;
    logic                 str2x;
    logic                 sio48;
    logic [7:0]           rdata;
    logic [SLC_DIV_W-1:0] div;
    logic [2:0]           cpu_cnt;
    logic [2:0]           agp_cnt;
    logic [3:0]           pci_cnt;
    logic                 cpu_clk;
    logic                 agp_clk;
    logic                 pci_clk;
    logic                 usb_clk;
    logic                 sio_clk;
    logic                 sio_ph;
    logic                 xtal;
    slc_pad_t [3:0]       fs_pad;
    slc_pad_t             mode_pad;
    slc_pad_t             mult_pad;
    slc_pad_t             pg_pad;
    slc_pad_t             cpu_t_pad;
    slc_pad_t             cpu_c_pad;
    logic [1:0]           cs_pair;
    logic [1:0]           agp_out;
    logic [4:0]           pci_out;
    logic                 pp;
    logic                 cur6;
    logic                 en;
  } slc_state_t;

  slc_state_t s_q;
  slc_state_t s_d;
  slc_freq_t  freq_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ==========================================================================
  // frequency decode, registered lookup
  slc_freq_rom u_rom (
    .clk_sys (clk_sys),
    .reset   (reset),
    .addr    (s_q.fs),
    .data_q  (freq_q)
  );

  // ==========================================================================
  // next state
  always_comb begin
    logic       run;
    logic       tick;
    logic [2:0] agp_last;
    logic [3:0] pci_last;
    run      = 1'b0;
    tick     = 1'b0;
    agp_last = 3'h0;
    pci_last = 4'h0;
    s_d = s_q;
    s_d.rdata = '0;
    s_d.xtal  = crystal_input;

    // power-up sequence
    unique case (s_q.st)
      SLC_ST_STRAP: begin
        if (supply_ok) begin
          s_d.mode = processor_mode_strap_i;
          if (!processor_mode_strap_i) begin
            s_d.fs   = freq_select_strap_i;
            s_d.mult = current_mult_strap_i;
            s_d.st   = SLC_ST_RUN;
          end else begin
            s_d.st = SLC_ST_WAIT_PG;
          end
        end
      end
      SLC_ST_WAIT_PG: begin
        // a low level counts: a board that ties the pin to ground must still start
        if (!power_good_n_in) begin
          s_d.fs   = freq_select_strap_i;
          s_d.mult = current_mult_strap_i;
          s_d.st   = SLC_ST_RUN;
        end
      end
      SLC_ST_RUN: begin
        // power-good is no longer looked at in this phase
        s_d.st = SLC_ST_RUN;
      end
      default: begin
        s_d.st = SLC_ST_STRAP;
      end
    endcase

    // clock model: one tick divider, all dividers restart together
    run = (s_q.st == SLC_ST_RUN);
    if (run) begin
      tick     = (s_q.div == SLC_DIV_LAST);
      agp_last = freq_q.agp_half - 3'h1;
      pci_last = {freq_q.agp_half, 1'b0} - 4'h1;
      s_d.div  = tick ? '0 : s_q.div + 1'b1;
      if (tick) begin
        s_d.usb_clk = ~s_q.usb_clk;
        s_d.sio_ph  = ~s_q.sio_ph;
        if (s_q.sio48 || s_q.sio_ph) begin
          s_d.sio_clk = ~s_q.sio_clk;
        end
        if (s_q.cpu_cnt == SLC_CPU_HALF_LAST) begin
          s_d.cpu_cnt = '0;
          s_d.cpu_clk = ~s_q.cpu_clk;
        end else begin
          s_d.cpu_cnt = s_q.cpu_cnt + 3'h1;
        end
        // graphics and pci edges share the cpu tick and start point
        if (s_q.agp_cnt == agp_last) begin
          s_d.agp_cnt = '0;
          s_d.agp_clk = ~s_q.agp_clk;
        end else begin
          s_d.agp_cnt = s_q.agp_cnt + 3'h1;
        end
        if (s_q.pci_cnt == pci_last) begin
          s_d.pci_cnt = '0;
          s_d.pci_clk = ~s_q.pci_clk;
        end else begin
          s_d.pci_cnt = s_q.pci_cnt + 4'h1;
        end
      end
    end else begin
      s_d.div     = '0;
      s_d.cpu_cnt = '0;
      s_d.agp_cnt = '0;
      s_d.pci_cnt = '0;
      s_d.cpu_clk = 1'b0;
      s_d.agp_clk = 1'b0;
      s_d.pci_clk = 1'b0;
      s_d.usb_clk = 1'b0;
      s_d.sio_clk = 1'b0;
      s_d.sio_ph  = 1'b0;
    end

    // pads; strap pins stay undriven until their value is held
    s_d.fs_pad[0] = '{o: run & s_q.xtal,    oe: run};
    s_d.fs_pad[1] = '{o: run & s_q.pci_clk, oe: run};
    s_d.fs_pad[2] = '{o: run & s_q.sio_clk, oe: run};
    s_d.fs_pad[3] = '{o: run & s_q.usb_clk, oe: run};
    s_d.mode_pad  = '{o: run & s_q.agp_clk, oe: s_q.st != SLC_ST_STRAP};
    s_d.mult_pad  = '{o: run & s_q.pci_clk, oe: run};
    s_d.pg_pad    = '{o: run & ~s_q.mode & s_q.xtal, oe: run & ~s_q.mode};
    if (run && s_q.mode) begin
      s_d.cpu_t_pad = '{o: s_q.cpu_clk,  oe: 1'b1};
      s_d.cpu_c_pad = '{o: ~s_q.cpu_clk, oe: 1'b1};
    end else if (run) begin
      // open drain: pull low only, the board resistor makes the high half
      s_d.cpu_t_pad = '{o: 1'b0, oe: ~s_q.cpu_clk};
      s_d.cpu_c_pad = '{o: 1'b0, oe: s_q.cpu_clk};
    end else begin
      s_d.cpu_t_pad = '0;
      s_d.cpu_c_pad = '0;
    end
    s_d.cs_pair = run ? {~s_q.cpu_clk, s_q.cpu_clk} : 2'h0;
    s_d.agp_out = {2{run & s_q.agp_clk}};
    s_d.pci_out = {5{run & s_q.pci_clk}};
    s_d.pp      = s_q.mode;
    s_d.cur6    = s_q.mult;
    s_d.en      = run;

    // register port
    if (reg_wr && reg_addr == SLC_REG_CTRL) begin
      s_d.str2x = reg_wdata[SLC_CTRL_STR_BIT];
      s_d.sio48 = reg_wdata[SLC_CTRL_SIO_BIT];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        SLC_REG_CTRL:   s_d.rdata = {6'h00, s_q.sio48, s_q.str2x};
        SLC_REG_STATUS: s_d.rdata = {s_q.st == SLC_ST_WAIT_PG, run, s_q.mult,
                                     s_q.mode, s_q.fs};
        SLC_REG_CPU_LO: s_d.rdata = freq_q.cpu_x10[7:0];
        SLC_REG_CPU_HI: s_d.rdata = {5'h00, freq_q.cpu_x10[10:8]};
        default:        s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q       <= '0;
      s_q.st    <= SLC_ST_STRAP;
      s_q.str2x <= SLC_CTRL_STR_RST;
      s_q.sio48 <= SLC_CTRL_SIO_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs
  assign freq_select_strap_pad  = s_q.fs_pad;
  assign processor_mode_pad     = s_q.mode_pad;
  assign current_mult_pad       = s_q.mult_pad;
  assign power_good_pad         = s_q.pg_pad;
  assign cpu_true_pad           = s_q.cpu_t_pad;
  assign cpu_comp_pad           = s_q.cpu_c_pad;
  assign chipset_cpu_clock_pair = s_q.cs_pair;
  assign graphics_port_clocks   = s_q.agp_out;
  assign pci_clocks             = s_q.pci_out;
  assign cpu_push_pull          = s_q.pp;
  assign cpu_current_6x         = s_q.cur6;
  assign ref_strength_2x        = s_q.str2x;
  assign outputs_enabled        = s_q.en;
  assign reg_rdata              = s_q.rdata;

  // ==========================================================================
  // checks
  sequence s_in_run2;
    (s_q.st == SLC_ST_RUN) ##1 (s_q.st == SLC_ST_RUN);
  endsequence

  sequence s_mode0_run2;
    (s_q.st == SLC_ST_RUN && !s_q.mode) ##1 (s_q.st == SLC_ST_RUN);
  endsequence

  sequence s_mode1_run2;
    (s_q.st == SLC_ST_RUN && s_q.mode) ##1 (s_q.st == SLC_ST_RUN);
  endsequence

  property p_strap_undriven;
    (s_q.st == SLC_ST_STRAP) ##1 (s_q.st == SLC_ST_STRAP)
      |-> (freq_select_strap_pad[0].oe == 1'b0) && (current_mult_pad.oe == 1'b0);
  endproperty
  a_strap_undriven: assert property (p_strap_undriven)
    else $error("strap pin driven before latch");

  property p_fs_frozen;
    s_in_run2 |-> $stable(s_q.fs) && $stable(s_q.mult) && $stable(s_q.mode);
  endproperty
  a_fs_frozen: assert property (p_fs_frozen)
    else $error("latched straps changed after start");

  property p_pg_latch;
    (s_q.st == SLC_ST_WAIT_PG && !power_good_n_in)
      |=> (s_q.st == SLC_ST_RUN) && (s_q.fs == $past(freq_select_strap_i))
          && (s_q.mult == $past(current_mult_strap_i)) ##1 outputs_enabled;
  endproperty
  a_pg_latch: assert property (p_pg_latch)
    else $error("power-good low did not latch and enable");

  property p_mode0_direct;
    (s_q.st == SLC_ST_STRAP && supply_ok && !processor_mode_strap_i)
      |=> (s_q.st == SLC_ST_RUN) && (s_q.fs == $past(freq_select_strap_i))
          && !s_q.mode;
  endproperty
  a_mode0_direct: assert property (p_mode0_direct)
    else $error("mode 0 did not start on threshold");

  property p_mode_latch;
    (s_q.st == SLC_ST_STRAP && supply_ok)
      |=> (s_q.mode == $past(processor_mode_strap_i)) ##1 processor_mode_pad.oe;
  endproperty
  a_mode_latch: assert property (p_mode_latch)
    else $error("mode strap not latched");

  property p_ref_b_copy;
    s_mode0_run2 |-> power_good_pad.oe && (power_good_pad.o == $past(crystal_input, 2));
  endproperty
  a_ref_b_copy: assert property (p_ref_b_copy)
    else $error("second crystal copy wrong in mode 0");

  property p_ref_a_copy;
    s_in_run2 |-> freq_select_strap_pad[0].oe
                  && (freq_select_strap_pad[0].o == $past(crystal_input, 2));
  endproperty
  a_ref_a_copy: assert property (p_ref_a_copy)
    else $error("first crystal copy wrong");

  property p_cpu_pp;
    s_mode1_run2 |-> cpu_true_pad.oe && cpu_comp_pad.oe
                     && (cpu_true_pad.o != cpu_comp_pad.o) && !power_good_pad.oe;
  endproperty
  a_cpu_pp: assert property (p_cpu_pp)
    else $error("cpu pair not push-pull in mode 1");

  property p_cpu_od;
    s_mode0_run2 |-> !cpu_true_pad.o && !cpu_comp_pad.o
                     && (cpu_true_pad.oe != cpu_comp_pad.oe);
  endproperty
  a_cpu_od: assert property (p_cpu_od)
    else $error("cpu pair not open-drain in mode 0");

  property p_current;
    s_in_run2 |-> cpu_current_6x == $past(s_q.mult);
  endproperty
  a_current: assert property (p_current)
    else $error("current multiplier does not follow strap");

  property p_strength;
    (reg_wr && reg_addr == SLC_REG_CTRL) |=> ref_strength_2x == $past(reg_wdata[0]);
  endproperty
  a_strength: assert property (p_strength)
    else $error("drive strength write lost");

  property p_sync_edges;
    (s_q.st == SLC_ST_RUN) && $changed(s_q.pci_clk) |-> $changed(s_q.agp_clk);
  endproperty
  a_sync_edges: assert property (p_sync_edges)
    else $error("pci edge not aligned to graphics edge");

  property p_decode0;
    s_in_run2 ##1 (s_q.fs == 4'h0) |-> freq_q.cpu_x10 == 11'h3F1;
  endproperty
  a_decode0: assert property (p_decode0)
    else $error("code 0000 did not decode to 100.9");

  property p_free_clocks;
    s_in_run2 |-> freq_select_strap_pad[1].oe && freq_select_strap_pad[2].oe
                  && freq_select_strap_pad[3].oe;
  endproperty
  a_free_clocks: assert property (p_free_clocks)
    else $error("strap pins not turned into outputs");

endmodule // slc_top
`default_nettype wire

// >>> design/slc_pkg.sv
package slc_pkg;

  // ==========================================================================
  // lifecycle phases
  typedef enum logic [1:0] {
    SLC_ST_STRAP,
    SLC_ST_WAIT_PG,
    SLC_ST_RUN
  } slc_phase_t;

  // ==========================================================================
  // pad carrier: output value and output enable of a two-way pin
  typedef struct packed {
    logic o;
    logic oe;
  } slc_pad_t;

  // ==========================================================================
  // frequency table entry, frequencies in tenths of MHz
  typedef struct packed {
    logic [10:0] cpu_x10;
    logic [10:0] agp_x10;
    logic [10:0] pci_x10;
    logic [2:0]  agp_half;
  } slc_freq_t;

  localparam slc_freq_t SLC_FREQ_TABLE [16] = '{
    '{11'h3F1, 11'h2A1, 11'h150, 3'h3},
    '{11'h3E8, 11'h29B, 11'h14D, 3'h3},
    '{11'h53B, 11'h29D, 11'h14F, 3'h4},
    '{11'h535, 11'h29B, 11'h14D, 3'h4},
    '{11'h44C, 11'h2DD, 11'h16F, 3'h3},
    '{11'h5AC, 11'h2D6, 11'h16B, 3'h4},
    '{11'h708, 11'h2D0, 11'h168, 3'h5},
    '{11'h7C0, 11'h2CD, 11'h166, 3'h6},
    '{11'h7D9, 11'h29D, 11'h14F, 3'h6},
    '{11'h7D0, 11'h29B, 11'h14D, 3'h6},
    '{11'h685, 11'h29C, 11'h14E, 3'h5},
    '{11'h682, 11'h29A, 11'h14D, 3'h5},
    '{11'h3E8, 11'h29B, 11'h14D, 3'h3},
    '{11'h535, 11'h29B, 11'h14D, 3'h4},
    '{11'h7D0, 11'h29B, 11'h14D, 3'h6},
    '{11'h682, 11'h29A, 11'h14D, 3'h5}
  };

  // ==========================================================================
  // clock model timing, in ticks and cycles
  localparam int unsigned SLC_TICK_DIV = 2;
  localparam int unsigned SLC_DIV_W    = 2;
  localparam logic [SLC_DIV_W-1:0] SLC_DIV_LAST = 2'h1;
  localparam logic [2:0] SLC_CPU_HALF_LAST = 3'h1;

  // ==========================================================================
  // register map
  localparam logic [3:0] SLC_REG_CTRL    = 4'h0;
  localparam logic [3:0] SLC_REG_STATUS  = 4'h1;
  localparam logic [3:0] SLC_REG_CPU_LO  = 4'h2;
  localparam logic [3:0] SLC_REG_CPU_HI  = 4'h3;
  localparam int unsigned SLC_CTRL_STR_BIT = 0;
  localparam int unsigned SLC_CTRL_SIO_BIT = 1;
  localparam logic SLC_CTRL_STR_RST = 1'b0;
  localparam logic SLC_CTRL_SIO_RST = 1'b1;

endpackage : slc_pkg

// >>> design/slc_freq_rom.sv
`timescale 1ns/10ps
`default_nettype none
module slc_freq_rom
  import slc_pkg::*;
(
  // clock and reset
  input  wire logic      clk_sys,
  input  wire logic      reset,
  // lookup
  input  wire logic [3:0] addr,
  output slc_freq_t       data_q
);

  slc_freq_t data_d;

  always_comb begin
    data_d = SLC_FREQ_TABLE[addr];
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      data_q <= '0;
    end else begin
      data_q <= data_d;
    end
  end

endmodule // slc_freq_rom
`default_nettype wire

// >>> tb/slc_board_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// board side: strap resistors on the shared pins and the power-good driver
module slc_board_model
  import slc_pkg::*;
(
  // board settings
  input  wire logic           [3:0] fs_level,
  input  wire logic                 mode_level,
  input  wire logic                 mult_level,
  input  wire logic                 pg_low,
  // device pads
  input  wire slc_pad_t       [3:0] freq_select_strap_pad,
  input  wire slc_pad_t             processor_mode_pad,
  input  wire slc_pad_t             current_mult_pad,
  input  wire slc_pad_t             power_good_pad,
  // resolved pin levels
  output logic                [3:0] freq_select_strap_i,
  output logic                      processor_mode_strap_i,
  output logic                      current_mult_strap_i,
  output logic                      power_good_n_in
);
  // a driving pad wins over the weak strap resistor
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      freq_select_strap_i[k] = freq_select_strap_pad[k].oe ? freq_select_strap_pad[k].o
                                                           : fs_level[k];
    end
    processor_mode_strap_i = processor_mode_pad.oe ? processor_mode_pad.o : mode_level;
    current_mult_strap_i   = current_mult_pad.oe ? current_mult_pad.o : mult_level;
    // power-good logic holds the line high until it asserts
    power_good_n_in        = power_good_pad.oe ? power_good_pad.o : ~pg_low;
  end
endmodule // slc_board_model
`default_nettype wire

// >>> tb/strap_latch_clock_select_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module strap_latch_clock_select_tb_top;
  import slc_pkg::*;
  logic clk_sys, reset, supply_ok, crystal_input, reg_wr, reg_rd, mode_level, mult_level, pg_low;
  logic [3:0] fs_level, fs_i, reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd, rd2;
  logic mode_i, mult_i, pg_n, cpu_push_pull, cpu_current_6x, ref_strength_2x, outputs_enabled;
  slc_pad_t [3:0] fs_pad;
  slc_pad_t mode_pad, mult_pad, pg_pad, cpu_true_pad, cpu_comp_pad;
  logic [1:0] chipset_pair, gfx, xh;
  logic [4:0] pci;
  logic [31:0] lfsr, xlfsr;
  logic cur_mode, pci_prev, gfx_prev, sio_fast;
  logic [3:0] cur_fs;
  logic [2:0] hi_now, hi_prev;
  logic [15:0] hi_len [3];
  logic [15:0] hi_exp [3];
  int num_errors, n_checks;
  localparam logic [10:0] CPU_X10 [16] = '{11'h3F1, 11'h3E8, 11'h53B, 11'h535, 11'h44C,
    11'h5AC, 11'h708, 11'h7C0, 11'h7D9, 11'h7D0, 11'h685, 11'h682, 11'h3E8, 11'h535,
    11'h7D0, 11'h682};

  slc_top slc_top_inst (.clk_sys(clk_sys), .reset(reset), .supply_ok(supply_ok),
    .crystal_input(crystal_input), .freq_select_strap_i(fs_i), .freq_select_strap_pad(fs_pad),
    .processor_mode_strap_i(mode_i), .processor_mode_pad(mode_pad),
    .current_mult_strap_i(mult_i), .current_mult_pad(mult_pad), .power_good_n_in(pg_n),
    .power_good_pad(pg_pad), .cpu_true_pad(cpu_true_pad), .cpu_comp_pad(cpu_comp_pad),
    .chipset_cpu_clock_pair(chipset_pair), .graphics_port_clocks(gfx), .pci_clocks(pci),
    .cpu_push_pull(cpu_push_pull), .cpu_current_6x(cpu_current_6x),
    .ref_strength_2x(ref_strength_2x), .outputs_enabled(outputs_enabled),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  slc_board_model slc_board_model_inst (.fs_level(fs_level), .mode_level(mode_level),
    .mult_level(mult_level), .pg_low(pg_low), .freq_select_strap_pad(fs_pad),
    .processor_mode_pad(mode_pad), .current_mult_pad(mult_pad), .power_good_pad(pg_pad),
    .freq_select_strap_i(fs_i), .processor_mode_strap_i(mode_i),
    .current_mult_strap_i(mult_i), .power_good_n_in(pg_n));

  // ==========================================================================
  // clock, random crystal pattern, helpers
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] next_lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] exp_status(input logic [3:0] fs, input logic mode, mult);
    return {2'h1, mult, mode, fs};
  endfunction
  always @(posedge clk_sys) begin
    xlfsr         <= next_lfsr(xlfsr);
    crystal_input <= xlfsr[7];
    xh            <= {xh[0], crystal_input};
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  // ==========================================================================
  // pin monitor: crystal copies, cpu pair style, clock alignment and high times
  always @(negedge clk_sys) begin
    if (outputs_enabled === 1'b1) begin
      check("crystal copy a", fs_pad[0].o, xh[1]);
      if (cur_mode === 1'b0) begin
        check("crystal copy b", pg_pad.o, xh[1]);
        check("open drain level", cpu_true_pad.o, 1'b0);
      end else begin
        check("push pull comp", cpu_comp_pad.o, !cpu_true_pad.o);
        check("push pull enable", cpu_true_pad.oe, 1'b1);
      end
      if (pci[0] !== pci_prev) check("pci in step", gfx[0] !== gfx_prev, 1'b1);
      check("graphics copies", {mode_pad.o, gfx[1]}, {2{gfx[0]}});
      check("pci copies", {mult_pad.o, fs_pad[1].o, pci[4:1]}, {6{pci[0]}});
      check("cpu pair", chipset_pair[1] !== chipset_pair[0], 1'b1);
      if (sio_fast) check("sio at 48", fs_pad[2].o, fs_pad[3].o);
      // high time of usb, cpu and graphics clocks, counted in cycles
      hi_now    = {gfx[0], chipset_pair[0], fs_pad[3].o};
      hi_exp[0] = 16'(SLC_TICK_DIV);
      hi_exp[1] = 16'((SLC_CPU_HALF_LAST + 1) * SLC_TICK_DIV);
      hi_exp[2] = 16'(SLC_FREQ_TABLE[cur_fs].agp_half * SLC_TICK_DIV);
      for (int k = 0; k < 3; k++) begin
        if (hi_prev[k] === 1'b1 && hi_now[k] === 1'b0)
          check("clock high time", hi_len[k], hi_exp[k]);
        hi_len[k] = (hi_now[k] !== hi_prev[k]) ? 16'h1 : hi_len[k] + 16'h1;
      end
      hi_prev = hi_now;
    end else begin
      hi_prev = 3'h0;
    end
    pci_prev = pci[0];
    gfx_prev = gfx[0];
  end

  // ==========================================================================
  // one full power-up with given straps; mode 1 moves the select straps late
  task automatic power_up(input logic [3:0] fs, input logic mode, mult);
    int i;
    @(posedge clk_sys);
    reset <= 1'b1; supply_ok <= 1'b0; pg_low <= 1'b0; cur_mode = mode;
    cur_fs = fs; sio_fast = 1'b1;
    fs_level <= mode ? ~fs : fs; mode_level <= mode; mult_level <= mult;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    check("ref strength default", ref_strength_2x, 1'b0);
    supply_ok <= 1'b1;
    if (mode) begin
      repeat (4) @(posedge clk_sys);
      check("held for power good", outputs_enabled, 1'b0);
      check("graphics pin driven", mode_pad.oe, 1'b1);
      reg_read(SLC_REG_STATUS, rd);
      check("waiting status", rd[7:6], 2'h2);
      @(posedge clk_sys);
      fs_level <= fs;
      @(posedge clk_sys);
      pg_low <= 1'b1;
    end
    for (i = 0; i < 20 && outputs_enabled !== 1'b1; i++) @(posedge clk_sys);
    check("outputs enabled", outputs_enabled, 1'b1);
    if (outputs_enabled !== 1'b1) report_and_stop();
    // later strap and power-good movement must change nothing
    fs_level <= ~fs; mult_level <= ~mult; mode_level <= ~mode; pg_low <= 1'b0;
    repeat (6) @(posedge clk_sys);
    pg_low <= 1'b1;
    repeat (6) @(posedge clk_sys);
    reg_read(SLC_REG_STATUS, rd);
    check("latched status", rd, exp_status(fs, mode, mult));
    check("still enabled", outputs_enabled, 1'b1);
    check("cpu style", cpu_push_pull, mode);
    check("current 6x", cpu_current_6x, mult);
    check("copy b enable", pg_pad.oe, !mode);
    check("strap pins driven", {fs_pad[3].oe, fs_pad[2].oe, fs_pad[1].oe}, 3'h7);
    check("pci pin driven", mult_pad.oe, 1'b1);
    reg_read(SLC_REG_CPU_LO, rd);
    reg_read(SLC_REG_CPU_HI, rd2);
    check("cpu frequency", {rd2[2:0], rd}, CPU_X10[fs]);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    reset = 1'b1; supply_ok = 1'b0; crystal_input = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 4'h0; reg_wdata = 8'h00; fs_level = 4'h0; mode_level = 1'b0;
    mult_level = 1'b0; pg_low = 1'b0; lfsr = 32'h8701; xlfsr = 32'h8701; xh = 2'h0;
    num_errors = 0; n_checks = 0; cur_mode = 1'b0;
    sio_fast = 1'b1; cur_fs = 4'h0; hi_prev = 3'h0;
    power_up(4'h5, 1'b0, 1'b1);
    reg_read(SLC_REG_CTRL, rd);
    check("ctrl reset", rd, 8'h02);
    @(negedge clk_sys);
    check("read data one cycle", reg_rdata, 8'h00);
    reg_write(SLC_REG_CTRL, 8'h01);
    @(negedge clk_sys);
    sio_fast = 1'b0;
    check("double strength", ref_strength_2x, 1'b1);
    reg_write(SLC_REG_STATUS, 8'hFF);
    reg_read(SLC_REG_STATUS, rd);
    check("status read only", rd, exp_status(4'h5, 1'b0, 1'b1));
    reg_read(4'hF, rd);
    check("unmapped read", rd, 8'h00);
    for (int c = 0; c < 16; c++) begin
      lfsr = next_lfsr(lfsr);
      power_up(c[3:0], c[0] ^ lfsr[5], lfsr[0]);
    end
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
endmodule // strap_latch_clock_select_tb_top
`default_nettype wire
